// File: drs_pkg.sv
// Constants shared by the request-select and bus-split block.
// Assumes a 32-bit Avalon-MM register bus and byte addresses.
package drs_pkg;
    localparam int DRS_CHANNELS = 4;
    localparam int DRS_SEL_W = 5;
    // Register byte offsets.
    localparam logic [5:0] DRS_OFF_SEL = 6'h00;
    localparam logic [5:0] DRS_OFF_CTRL = 6'h10;
    localparam logic [5:0] DRS_OFF_XFER = 6'h14;
    localparam logic [5:0] DRS_OFF_SRCA = 6'h18;
    localparam logic [5:0] DRS_OFF_DSTA = 6'h1c;
    localparam logic [5:0] DRS_OFF_STAT = 6'h20;
    localparam logic [5:0] DRS_OFF_PEND = 6'h24;
    localparam logic [7:0] DRS_SEL_RESET = 8'h00;
    // Extended source-select codes.
    localparam logic [4:0] DRS_CODE_SW = 5'h00;
    localparam logic [4:0] DRS_CODE_FALL = 5'h01;
    localparam logic [4:0] DRS_CODE_BOTH = 5'h02;
    localparam logic [4:0] DRS_CODE_S7TX = 5'h18;
    localparam logic [4:0] DRS_CODE_S7RX = 5'h19;
    localparam logic [4:0] DRS_CODE_S8TX = 5'h1a;
    localparam logic [4:0] DRS_CODE_S8RX = 5'h1b;
    // Transfer units and bus widths.
    localparam logic [1:0] DRS_UNIT_8 = 2'h0;
    localparam logic [1:0] DRS_UNIT_16 = 2'h1;
    localparam logic [1:0] DRS_UNIT_32 = 2'h2;
    localparam logic [1:0] DRS_BUS_8 = 2'h0;
    localparam logic [1:0] DRS_BUS_16 = 2'h1;
    localparam logic [1:0] DRS_BUS_32 = 2'h2;
    localparam logic [1:0] DRS_BUS_64 = 2'h3;
    // Control register fields.
    localparam int DRS_CTRL_UNIT_LO = 0;
    localparam int DRS_CTRL_SBUS_LO = 2;
    localparam int DRS_CTRL_DBUS_LO = 4;
    localparam int DRS_CTRL_EXPAND = 6;
    localparam int DRS_CTRL_TWOWIRE = 7;
    localparam int DRS_CTRL_ACK_LO = 8;
    // Selector bits above the extended code, and the first high pin.
    localparam int DRS_SEL_PIN = 5;
    localparam int DRS_SEL_BOTH = 6;
    localparam int DRS_SEL_SER = 7;
    localparam int DRS_HI_PIN_LO = 6;
    localparam logic [15:0] DRS_CTRL_RESET = 16'h0000;
    localparam logic [31:0] DRS_ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] DRS_ADDR_STEP = 32'h0000_0001;
    typedef enum logic [1:0] {DRS_IDLE, DRS_READ, DRS_WRITE} drs_state_e;
endpackage

// File: drs_dma_request_and_bus_split.sv
// Request source selection and bus cycle splitting for four DMA channels.
// Assumes pins are asynchronous and the bus consumer drives cyc_ready.
//
// How it works
// - Pins 0-3 edges request DMA, no IRQ coupling.
// - Pins 6-8 edges request DMA, no IRQ coupling.
// - Pin 3 ignored for channel 3 in expansion.
// - Mode bits pick serial receive or acknowledge.
// - Two-wire bit picks serial two or I2C.
// - Five-bit code per channel; zero is software.
// - Code 1: falling edge pins 6-8; ch3 reserved.
// - Code 2: both edges pins 6-8; ch3 reserved.
// - Codes 18h,19h: serial seven transmit, receive.
// - Codes 1Ah,1Bh: serial eight; others reserved.
// - Transfer is source reads then destination writes.
// - Cycle count follows address and bus width.
// - Byte unit always one cycle.
// - Halfword adds one on 8-bit or crossing.
// - Word on 8-bit bus takes four cycles.
// - Word on 16-bit bus takes two or three.
// - Word on 32-bit: one aligned, else two; on 64-bit: two only above offset 4.
`timescale 1ns/1ps
`default_nettype none
module drs_dma_request_and_bus_split
    import drs_pkg::*;
#(
    parameter int CHANNELS = DRS_CHANNELS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave.
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Asynchronous event pins 0 to 8.
    input wire logic [8:0] ext_event_pin,
    // Peripheral request levels from the serial ports, same clock.
    input wire logic [6:0] serial_rx_req,
    input wire logic [6:0] serial_ack_req,
    input wire logic twowire_req,
    input wire logic [1:0] serial_hi_tx_req,
    input wire logic [1:0] serial_hi_rx_req,
    // Selected request per channel and acknowledge from the engine.
    output logic [3:0] dma_request,
    input wire logic [3:0] dma_request_ack,
    // Split bus cycles out of the two-entry buffer.
    output logic cyc_valid,
    input wire logic cyc_ready,
    output logic [31:0] cyc_addr,
    output logic cyc_is_write,
    output logic cyc_last
);
    logic [7:0] sel [4];
    logic [15:0] ctrl;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [8:0] pin_s1;
    logic [8:0] pin_s2;
    logic [8:0] pin_d;
    logic [3:0] pend;
    drs_state_e state;
    logic [31:0] cur_addr;
    logic [1:0] left;
    logic [1:0] buf_cnt;
    logic [33:0] buf_mem [2];
    logic buf_wp;
    logic buf_rp;
    logic avs_ack;

    // Number of extra bus cycles for a unit at an address on a bus.
    function automatic logic [1:0] extra_cycles(input logic [1:0] unit,
        input logic [1:0] bw, input logic [2:0] a);
        logic [1:0] r;
        r = 2'h0;
        if (unit == DRS_UNIT_16) begin
            if (bw == DRS_BUS_8 || (bw == DRS_BUS_16 && a[0])
                || (bw == DRS_BUS_32 && a[1:0] == 2'h3)
                || (bw == DRS_BUS_64 && a == 3'h7)) begin
                r = 2'h1;
            end
        end else if (unit == DRS_UNIT_32) begin
            unique case (bw)
                DRS_BUS_8: r = 2'h3;
                DRS_BUS_16: r = a[0] ? 2'h2 : 2'h1;
                DRS_BUS_32: r = (a[1:0] == 2'h0) ? 2'h0 : 2'h1;
                DRS_BUS_64: r = (a > 3'h4) ? 2'h1 : 2'h0;
            endcase
        end
        return r;
    endfunction

    // Address of the next split cycle: next aligned unit of the bus.
    function automatic logic [31:0] next_cycle_addr(input logic [31:0] a,
        input logic [1:0] bw);
        logic [31:0] m;
        m = 32'h0000_0000;
        unique case (bw)
            DRS_BUS_8: m = 32'h0000_0000;
            DRS_BUS_16: m = 32'h0000_0001;
            DRS_BUS_32: m = 32'h0000_0003;
            DRS_BUS_64: m = 32'h0000_0007;
        endcase
        return (a | m) + DRS_ADDR_STEP;
    endfunction

    wire [1:0] unit = ctrl[DRS_CTRL_UNIT_LO +: 2];
    wire [1:0] src_bus = ctrl[DRS_CTRL_SBUS_LO +: 2];
    wire [1:0] dst_bus = ctrl[DRS_CTRL_DBUS_LO +: 2];
    wire expand_mode = ctrl[DRS_CTRL_EXPAND];
    wire twowire_select_bit = ctrl[DRS_CTRL_TWOWIRE];
    wire [6:0] ack_mode = ctrl[DRS_CTRL_ACK_LO +: 7];

    // Pin edge detect on synchronised samples only.
    wire [8:0] pin_fall = pin_d & ~pin_s2;
    wire [8:0] pin_both = pin_d ^ pin_s2;
    wire pin3_ok = ~expand_mode;

    // Serial request routing.
    wire [6:0] serial_req_raw = (ack_mode & serial_ack_req)
        | (~ack_mode & serial_rx_req);
    wire [6:0] serial_req = {serial_req_raw[6:3],
        twowire_select_bit ? twowire_req : serial_req_raw[2],
        serial_req_raw[1:0]};

    // Per-channel source select: table codes and the channel pin.
    logic [3:0] hw_event;
    logic [3:0] sw_trigger;
    // Channels 0 to 2 own pins 6 to 8; channel 3 has no such pin.
    wire [3:0] hi_fall = {1'b0, pin_fall[DRS_HI_PIN_LO +: 3]};
    wire [3:0] hi_both = {1'b0, pin_both[DRS_HI_PIN_LO +: 3]};
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            unique case (sel[c][4:0])
                DRS_CODE_SW: hw_event[c] = 1'b0;
                DRS_CODE_FALL: hw_event[c] = hi_fall[c];
                DRS_CODE_BOTH: hw_event[c] = hi_both[c];
                DRS_CODE_S7TX: hw_event[c] = serial_hi_tx_req[0];
                DRS_CODE_S7RX: hw_event[c] = serial_hi_rx_req[0];
                DRS_CODE_S8TX: hw_event[c] = serial_hi_tx_req[1];
                DRS_CODE_S8RX: hw_event[c] = serial_hi_rx_req[1];
                default: hw_event[c] = 1'b0;
            endcase
            // The pin bit asks for the channel pin edge, or both edges.
            if (sel[c][DRS_SEL_PIN] && (c != 3 || pin3_ok)) begin
                hw_event[c] = hw_event[c] | (sel[c][DRS_SEL_BOTH]
                    ? pin_both[c] : pin_fall[c]);
            end
            // The serial bit adds the routed serial request of the channel.
            hw_event[c] = hw_event[c]
                | (sel[c][DRS_SEL_SER] & serial_req[c]);
        end
    end

    // A write lands only on the edge that ends the acknowledged cycle after the wait state.
    wire bus_wr = avs_write && avs_ack;
    wire hit_sel = avs_address[5:4] == DRS_OFF_SEL[5:4];
    wire [1:0] sel_idx = avs_address[3:2];
    assign sw_trigger = (bus_wr && avs_address == DRS_OFF_PEND)
        ? avs_writedata[3:0] : 4'h0;

    // Register file with one wait state on every access.
    assign avs_waitrequest = (avs_read || avs_write) && !avs_ack;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < 4; c++) begin
                sel[c] <= DRS_SEL_RESET;
            end
            ctrl <= DRS_CTRL_RESET;
            src_addr <= DRS_ADDR_RESET;
            dst_addr <= DRS_ADDR_RESET;
            avs_ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_ack <= (avs_read || avs_write) && !avs_ack;
            if (bus_wr && hit_sel && avs_byteenable[0]) begin
                sel[sel_idx] <= avs_writedata[7:0];
            end
            if (bus_wr && avs_address == DRS_OFF_CTRL) begin
                ctrl <= avs_writedata[15:0];
            end
            if (bus_wr && avs_address == DRS_OFF_SRCA) begin
                src_addr <= avs_writedata;
            end
            if (bus_wr && avs_address == DRS_OFF_DSTA) begin
                dst_addr <= avs_writedata;
            end
            if (avs_read && !avs_ack) begin
                if (hit_sel) begin
                    avs_readdata <= {24'h00_0000, sel[sel_idx]};
                end else if (avs_address == DRS_OFF_CTRL) begin
                    avs_readdata <= {16'h0000, ctrl};
                end else if (avs_address == DRS_OFF_SRCA) begin
                    avs_readdata <= src_addr;
                end else if (avs_address == DRS_OFF_DSTA) begin
                    avs_readdata <= dst_addr;
                end else if (avs_address == DRS_OFF_STAT) begin
                    avs_readdata <= {28'h000_0000, buf_cnt, state};
                end else if (avs_address == DRS_OFF_PEND) begin
                    avs_readdata <= {28'h000_0000, pend};
                end else begin
                    avs_readdata <= 32'h0000_0000;
                end
            end
        end
    end

    // Pin synchronisers and the pending-request latches.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1 <= 9'h000;
            pin_s2 <= 9'h000;
            pin_d <= 9'h000;
            pend <= 4'h0;
        end else begin
            pin_s1 <= ext_event_pin;
            pin_s2 <= pin_s1;
            pin_d <= pin_s2;
            // A new event wins over the acknowledge in the same cycle.
            pend <= (pend & ~dma_request_ack) | hw_event | sw_trigger;
        end
    end
    assign dma_request = pend;

    // Split engine: reads of the source, then writes of the destination.
    wire buf_full = buf_cnt == 2'h2;
    wire push = (state != DRS_IDLE) && !buf_full;
    wire pop = cyc_valid && cyc_ready;
    wire start = sw_trigger[0] && state == DRS_IDLE;
    wire [1:0] bus_now = (state == DRS_WRITE) ? dst_bus : src_bus;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= DRS_IDLE;
            cur_addr <= DRS_ADDR_RESET;
            left <= 2'h0;
        end else if (start) begin
            state <= DRS_READ;
            cur_addr <= src_addr;
            left <= extra_cycles(unit, src_bus, src_addr[2:0]);
        end else if (push && left != 2'h0) begin
            cur_addr <= next_cycle_addr(cur_addr, bus_now);
            left <= left - 2'h1;
        end else if (push && state == DRS_READ) begin
            state <= DRS_WRITE;
            cur_addr <= dst_addr;
            left <= extra_cycles(unit, dst_bus, dst_addr[2:0]);
        end else if (push) begin
            state <= DRS_IDLE;
        end
    end

    // Two-entry buffer between the splitter and the bus.
    wire [33:0] entry = {state == DRS_WRITE,
        state == DRS_WRITE && left == 2'h0, cur_addr};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_cnt <= 2'h0;
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_mem[0] <= 34'h0_0000_0000;
            buf_mem[1] <= 34'h0_0000_0000;
        end else begin
            if (push) begin
                buf_mem[buf_wp] <= entry;
                buf_wp <= ~buf_wp;
            end
            if (pop) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
        end
    end
    assign cyc_valid = buf_cnt != 2'h0;
    assign cyc_addr = buf_mem[buf_rp][31:0];
    assign cyc_last = buf_mem[buf_rp][32];
    assign cyc_is_write = buf_mem[buf_rp][33];

    // Checks.
    property p_byte_one;
        @(posedge clk) disable iff (rst)
        start && unit == DRS_UNIT_8 |=> state == DRS_READ ##1
        state == DRS_WRITE || buf_full;
    endproperty
    a_byte_one: assert property (p_byte_one)
        else $error("byte unit not single cycle");
    property p_sw_code;
        @(posedge clk) disable iff (rst)
        sel[0][7:0] == 8'h00 && !sw_trigger[0] && !pend[0]
        |=> !pend[0];
    endproperty
    a_sw_code: assert property (p_sw_code)
        else $error("code zero raised hardware request");
    property p_ch3_reserved;
        @(posedge clk) disable iff (rst)
        sel[3] == {3'h0, DRS_CODE_FALL} |-> !hw_event[3];
    endproperty
    a_ch3_reserved: assert property (p_ch3_reserved)
        else $error("channel three took reserved code");
    property p_pin3_block;
        @(posedge clk) disable iff (rst)
        expand_mode && sel[3][7:5] == 3'h1 && sel[3][4:0] == 5'h00
        |-> !hw_event[3];
    endproperty
    a_pin3_block: assert property (p_pin3_block)
        else $error("pin three requested in expansion mode");
    property p_fall_req;
        @(posedge clk) disable iff (rst)
        sel[0] == {3'h0, DRS_CODE_FALL} && pin_fall[6] |=> pend[0];
    endproperty
    a_fall_req: assert property (p_fall_req)
        else $error("falling edge lost");
    property p_s7;
        @(posedge clk) disable iff (rst)
        sel[1] == {3'h0, DRS_CODE_S7RX} && serial_hi_rx_req[0]
        |=> pend[1];
    endproperty
    a_s7: assert property (p_s7)
        else $error("serial seven receive lost");
    property p_s8;
        @(posedge clk) disable iff (rst)
        sel[2] == {3'h0, DRS_CODE_S8TX} && serial_hi_tx_req[1]
        |=> pend[2];
    endproperty
    a_s8: assert property (p_s8)
        else $error("serial eight transmit lost");
    property p_order;
        @(posedge clk) disable iff (rst)
        state == DRS_WRITE |=> state != DRS_READ;
    endproperty
    a_order: assert property (p_order)
        else $error("read after write in one transfer");
    property p_ascend;
        @(posedge clk) disable iff (rst)
        push && left != 2'h0 && !start |=> cur_addr > $past(cur_addr);
    endproperty
    a_ascend: assert property (p_ascend)
        else $error("split cycle address not ascending");
    property p_word8;
        @(posedge clk) disable iff (rst)
        start && unit == DRS_UNIT_32 && src_bus == DRS_BUS_8
        |=> left == 2'h3;
    endproperty
    a_word8: assert property (p_word8)
        else $error("word on byte bus not four cycles");
    property p_both_req;
        @(posedge clk) disable iff (rst)
        sel[0] == {3'h0, DRS_CODE_BOTH} && hi_both[0] |=> pend[0];
    endproperty
    a_both_req: assert property (p_both_req)
        else $error("both-edge request lost");
    property p_ch3_both;
        @(posedge clk) disable iff (rst)
        sel[3] == {3'h0, DRS_CODE_BOTH} |-> !hw_event[3];
    endproperty
    a_ch3_both: assert property (p_ch3_both)
        else $error("channel three took reserved both-edge code");
    property p_last_write;
        @(posedge clk) disable iff (rst)
        cyc_valid && cyc_last |-> cyc_is_write;
    endproperty
    a_last_write: assert property (p_last_write)
        else $error("final cycle of a transfer is not a write");
    property p_byte_cycles;
        @(posedge clk) disable iff (rst)
        start && unit == DRS_UNIT_8 |=> left == 2'h0;
    endproperty
    a_byte_cycles: assert property (p_byte_cycles)
        else $error("byte unit asked for extra cycles");
    property p_half8;
        @(posedge clk) disable iff (rst)
        start && unit == DRS_UNIT_16 && src_bus == DRS_BUS_8
        |=> left == 2'h1;
    endproperty
    a_half8: assert property (p_half8)
        else $error("halfword on byte bus not two cycles");
    property p_wait_one;
        @(posedge clk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("register access held more than one wait state");
endmodule
`default_nettype wire

// File: drs_bus_sink.sv
// Partner model: the memories and peripherals that take split cycles.
// Assumes the bench picks prompt or slow acceptance through slow.
`timescale 1ns/1ps
`default_nettype none
module drs_bus_sink (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Split cycle stream.
    input wire logic cyc_valid,
    output logic cyc_ready,
    // Pace control.
    input wire logic slow
);
    logic [1:0] pace;
    // A slow device takes one cycle in four so that the buffer fills.
    assign cyc_ready = ~slow | (pace == 2'h3);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pace <= 2'h0;
        end else begin
            pace <= pace + 2'h1;
        end
    end
endmodule
`default_nettype wire

// File: dma_request_and_bus_split_tb.sv
// Testbench for request selection and bus cycle splitting.
// Assumes the bus sink partner and the design package.
`timescale 1ns/1ps
`default_nettype none
module dma_request_and_bus_split_tb;
    import drs_pkg::*;
    logic clk = 0, rst = 1, rd_x = 0, wr_x = 0, slow = 0, tw = 0;
    logic [5:0] adr = 0;
    logic [31:0] wd = 0, rdat, cyc_addr, got;
    logic [3:0] be = 4'hf, ack = 0, req;
    logic [8:0] pin = 9'h1ff;
    logic [6:0] srx = 0, sack = 0;
    logic [1:0] htx = 0, hrx = 0;
    logic wrq, cyc_valid, cyc_ready, cyc_w, cyc_last;
    int n_errors = 0, checks_done = 0;
    logic [32:0] exp_q[$];
    always #4 clk = ~clk;
    drs_dma_request_and_bus_split drs_dma_request_and_bus_split_i (
        .clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_x),
        .avs_write(wr_x), .avs_writedata(wd), .avs_byteenable(be),
        .avs_readdata(rdat), .avs_waitrequest(wrq), .ext_event_pin(pin),
        .serial_rx_req(srx), .serial_ack_req(sack), .twowire_req(tw),
        .serial_hi_tx_req(htx), .serial_hi_rx_req(hrx),
        .dma_request(req), .dma_request_ack(ack), .cyc_valid(cyc_valid),
        .cyc_ready(cyc_ready), .cyc_addr(cyc_addr), .cyc_is_write(cyc_w),
        .cyc_last(cyc_last));
    drs_bus_sink drs_bus_sink_i (.clk(clk), .rst(rst),
        .cyc_valid(cyc_valid), .cyc_ready(cyc_ready), .slow(slow));
    task automatic print_verdict;
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk);
        adr <= a; wd <= d; rd_x <= ~w; wr_x <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wrq === 1'b0) break;
        end
        got = rdat;
        rd_x <= 1'b0; wr_x <= 1'b0;
        if (i == 20) begin n_errors++; print_verdict(); end
    endtask
    task automatic clr;
        ack <= 4'hf;
        @(posedge clk);
        ack <= 4'h0;
        repeat (2) @(posedge clk);
    endtask
    // Settle, compare the request lines, then clear them.
    task automatic exp_req(input logic [3:0] e);
        repeat (6) @(posedge clk);
        chk({29'h0, req}, {29'h0, e});
        clr();
    endtask
    task automatic add_split(input int a, input int nb, input int bb,
                             input logic w);
        int p;
        p = a;
        while (p < a + nb) begin
            exp_q.push_back({w, p[31:0]});
            p = (p / bb + 1) * bb;
        end
    endtask
    task automatic run_split(input int u, input int bw, input int off);
        int sa, da, k, n;
        sa = 256 + off;
        da = 520 + 7 - off;
        exp_q = {};
        add_split(sa, 1 << u, 1 << bw, 1'b0);
        add_split(da, 1 << u, 1 << (3 - bw), 1'b1);
        n = exp_q.size();
        slow <= off[0];
        bus(1, DRS_OFF_SRCA, sa);
        bus(1, DRS_OFF_DSTA, da);
        bus(1, DRS_OFF_CTRL, ((3 - bw) << 4) | (bw << 2) | u);
        bus(1, DRS_OFF_PEND, 32'h0000_0001);
        k = 0;
        for (int t = 0; t < 300 && k < n; t++) begin
            @(posedge clk);
            if (cyc_valid === 1'b1 && cyc_ready === 1'b1) begin
                chk({cyc_w, cyc_addr}, exp_q[k]);
                chk(cyc_last, k == n - 1);
                k++;
            end
        end
        chk(k, n);
        clr();
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({req, cyc_valid}, 0);
        bus(0, DRS_OFF_SEL, 0);
        chk(got, DRS_SEL_RESET);
        bus(0, DRS_OFF_CTRL, 0);
        chk(got, DRS_CTRL_RESET);
        bus(1, 6'h14, 32'hffff_ffff);
        bus(0, 6'h14, 0);
        chk(got, 0);
        bus(1, 6'h04, 32'h0000_001a);
        be <= 4'h0;
        bus(1, 6'h04, 32'h0000_0019);
        be <= 4'hf;
        bus(0, 6'h04, 0);
        chk(got, 32'h0000_001a);
        bus(1, 6'h04, 0);
        // Software trigger on channels one to three.
        bus(1, DRS_OFF_PEND, 32'h0000_000e);
        bus(0, DRS_OFF_PEND, 0);
        chk(got, 32'h0000_000e);
        exp_req(4'he);
        // Falling and both edges of pins six to eight.
        for (int c = 0; c < 3; c++) begin
            for (int b = 0; b < 2; b++) begin
                bus(1, 4 * c, b ? DRS_CODE_BOTH : DRS_CODE_FALL);
                bus(1, 6'h0c, b ? DRS_CODE_BOTH : DRS_CODE_FALL);
                pin[6 + c] <= 1'b0;
                exp_req(4'h1 << c);
                pin[6 + c] <= 1'b1;
                exp_req(b ? 4'h1 << c : 4'h0);
            end
            bus(1, 4 * c, 0);
        end
        bus(1, 6'h0c, 0);
        // High serial ports on every channel, others stay silent.
        for (int k = 0; k < 4; k++) begin
            for (int c = 0; c < 4; c++) bus(1, 4 * c, DRS_CODE_S7TX + k);
            htx <= {k != 2, k != 0};
            hrx <= {k != 3, k != 1};
            exp_req(4'h0);
            htx <= 2'h3;
            hrx <= 2'h3;
            exp_req(4'hf);
            htx <= 2'h0;
            hrx <= 2'h0;
            clr();
        end
        for (int c = 0; c < 4; c++) bus(1, 4 * c, 0);
        // Pin three blocked for channel three in expansion mode.
        bus(1, 6'h0c, 32'h0000_0020);
        bus(1, DRS_OFF_CTRL, 32'h0000_0040);
        pin[3] <= 1'b0;
        exp_req(4'h0);
        pin[3] <= 1'b1;
        exp_req(4'h0);
        bus(1, DRS_OFF_CTRL, 0);
        pin[3] <= 1'b0;
        exp_req(4'h8);
        pin[3] <= 1'b1;
        clr();
        bus(1, 6'h0c, 0);
        // Receive or acknowledge choice, and the two-wire choice.
        bus(1, 6'h00, 32'h0000_0080);
        bus(1, 6'h08, 32'h0000_0080);
        for (int m = 0; m < 2; m++) begin
            bus(1, DRS_OFF_CTRL, m << 8);
            sack[0] <= 1'b1;
            exp_req(m ? 4'h1 : 4'h0);
            sack[0] <= 1'b0;
            clr();
            srx[0] <= 1'b1;
            exp_req(m ? 4'h0 : 4'h1);
            srx[0] <= 1'b0;
            clr();
            bus(1, DRS_OFF_CTRL, m << 7);
            tw <= 1'b1;
            exp_req(m ? 4'h4 : 4'h0);
            tw <= 1'b0;
            clr();
            srx[2] <= 1'b1;
            exp_req(m ? 4'h0 : 4'h4);
            srx[2] <= 1'b0;
            clr();
        end
        bus(1, 6'h00, 0);
        bus(1, 6'h08, 0);
        // Every unit, bus width and alignment, prompt and stalled.
        for (int u = 0; u < 3; u++)
            for (int bw = 0; bw < 4; bw++)
                for (int off = 0; off < 8; off++)
                    run_split(u, bw, off);
        run_split(2, 1, 1);
        print_verdict();
    end
endmodule
`default_nettype wire
